// ===== logic/bwdep_pkg.sv
package bwdep_pkg;
  // host i/o decode
  localparam logic [15:0] BWDEP_ADDR_SERMEM = 16'h0100;
  localparam logic [15:0] BWDEP_ADDR_WDOG   = 16'h0101;
  // field positions
  localparam int BWDEP_WDOG_EN_BIT = 0;
  localparam int BWDEP_SM_DI_BIT   = 2;
  localparam int BWDEP_SM_SK_BIT   = 1;
  localparam int BWDEP_SM_CS_BIT   = 0;
  // reset values
  localparam logic       BWDEP_WDOG_EN_RST = 1'b0;
  localparam logic [2:0] BWDEP_SM_RST      = 3'h0;
  // timing
  localparam longint BWDEP_CLK_HZ        = 100000000;
  localparam longint BWDEP_WDOG_TIME_MS  = 500;
  localparam longint BWDEP_WDOG_CYC      = (BWDEP_WDOG_TIME_MS * BWDEP_CLK_HZ) / 1000;
  localparam int     BWDEP_CNT_W         = 26;
  localparam int     BWDEP_RST_PULSE_CYC = 16;
  // memory geometry, software side only
  localparam int BWDEP_MEM_WORDS = 64;
  localparam int BWDEP_MEM_USER0 = 32;
  // host access state
  typedef enum logic [1:0] {BWDEP_IDLE, BWDEP_RESP} bwdep_acc_t;
endpackage

// ===== logic/bwdep_if.sv
`timescale 1ns/1ns
`default_nettype none
// events between the host port decode and the watchdog timer, expiry going back to the port
interface bwdep_if;
  logic enabled;
  logic kick;
  logic expire;
  modport port_side (output enabled, output kick, input expire);
  modport timer_side (input enabled, input kick, output expire);
endinterface
`default_nettype wire

// ===== logic/bwdep_timer.sv
`timescale 1ns/1ns
`default_nettype none
module bwdep_timer #(
  parameter logic [bwdep_pkg::BWDEP_CNT_W-1:0] TIMEOUT_CYC =
    bwdep_pkg::BWDEP_CNT_W'(bwdep_pkg::BWDEP_WDOG_CYC)
) (
  input  wire logic clock,
  input  wire logic srst,
  bwdep_if.timer_side tif
);
  import bwdep_pkg::*;
  logic [BWDEP_CNT_W-1:0] cnt_r;
  logic                   exp_r;
  wire  cnt_done = (cnt_r == TIMEOUT_CYC - 1'b1);
  assign tif.expire = exp_r;

  // count board clocks since the last restart while armed
  always_ff @(posedge clock) begin
    if (srst || !tif.enabled || tif.kick) begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_done ? '0 : cnt_r + 1'b1;
      exp_r <= cnt_done;
    end
  end

  chk_expire_after_interval: assert property (@(posedge clock) disable iff (srst)
    exp_r |-> $past(tif.enabled) && !$past(tif.kick))
    else $error("expiry without an armed idle interval");
endmodule
`default_nettype wire

// ===== logic/bwdep_top.sv
`timescale 1ns/1ns
`default_nettype none
module bwdep_top #(
  parameter logic [bwdep_pkg::BWDEP_CNT_W-1:0] TIMEOUT_CYC =
    bwdep_pkg::BWDEP_CNT_W'(bwdep_pkg::BWDEP_WDOG_CYC)
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output var  logic [7:0]  io_rdata,
  output var  logic        io_rvalid,
  output var  logic        cpu_reset,
  output var  logic        slot_reset,
  output var  logic        mem_cs,
  output var  logic        mem_sk,
  output var  logic        mem_di,
  input  wire logic        mem_do,
  output var  logic        wdog_armed
);
  import bwdep_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire sel_mem  = (io_addr == BWDEP_ADDR_SERMEM);
  wire sel_wdog = (io_addr == BWDEP_ADDR_WDOG);
  wire wr_mem   = io_wr && sel_mem;
  wire wr_wdog  = io_wr && sel_wdog;
  wire rd_wdog  = io_rd && sel_wdog;
  wire rd_mem   = io_rd && sel_mem;

  bwdep_if tif ();
  logic        en_r;
  logic [4:0]  rst_cnt_r;
  bwdep_acc_t  acc_r;
  logic        do_r;

  assign tif.enabled = en_r;
  assign tif.kick    = rd_wdog;

  bwdep_timer #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_timer (
    .clock (clock),
    .srst  (srst),
    .tif   (tif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // arm control, cleared by any reset including its own
  always_ff @(posedge clock) begin
    if (srst || tif.expire)
      en_r <= BWDEP_WDOG_EN_RST;
    else if (wr_wdog)
      en_r <= io_wdata[BWDEP_WDOG_EN_BIT];
  end
  always_ff @(posedge clock) begin
    if (srst)
      wdog_armed <= 1'b0;
    else
      wdog_armed <= (srst || tif.expire) ? 1'b0 : (wr_wdog ? io_wdata[BWDEP_WDOG_EN_BIT] : en_r);
  end

  // stretched reset pulse to processor and slots
  always_ff @(posedge clock) begin
    if (srst)
      rst_cnt_r <= '0;
    else if (tif.expire)
      rst_cnt_r <= 5'(BWDEP_RST_PULSE_CYC);
    else if (rst_cnt_r != 0)
      rst_cnt_r <= rst_cnt_r - 1'b1;
  end
  // one drive term feeds both reset outputs so they cannot drift apart
  wire pulse_on = tif.expire || (rst_cnt_r > 5'h01);
  always_ff @(posedge clock) begin
    if (srst) begin
      cpu_reset  <= 1'b0;
      slot_reset <= 1'b0;
    end else begin
      cpu_reset  <= pulse_on;
      slot_reset <= pulse_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial memory control lines
  always_ff @(posedge clock) begin
    if (srst) begin
      mem_di <= BWDEP_SM_RST[BWDEP_SM_DI_BIT];
      mem_sk <= BWDEP_SM_RST[BWDEP_SM_SK_BIT];
      mem_cs <= BWDEP_SM_RST[BWDEP_SM_CS_BIT];
    end else if (wr_mem) begin
      mem_di <= io_wdata[BWDEP_SM_DI_BIT];
      mem_sk <= io_wdata[BWDEP_SM_SK_BIT];
      mem_cs <= io_wdata[BWDEP_SM_CS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read answer one cycle after the strobe
  wire [7:0] rd_val = rd_mem ? {7'h00, mem_do} : 8'h00;
  always_ff @(posedge clock) begin
    do_r <= mem_do;
    if (srst) begin
      acc_r     <= BWDEP_IDLE;
      io_rdata  <= 8'h00;
      io_rvalid <= 1'b0;
    end else begin
      case (acc_r)
        BWDEP_IDLE: begin
          io_rvalid <= io_rd;
          io_rdata  <= rd_val;
          acc_r     <= io_rd ? BWDEP_RESP : BWDEP_IDLE;
        end
        BWDEP_RESP: begin
          io_rvalid <= io_rd;
          io_rdata  <= rd_val;
          acc_r     <= io_rd ? BWDEP_RESP : BWDEP_IDLE;
        end
        default: acc_r <= BWDEP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_expire;
    tif.expire;
  endsequence
  chk_reset_both_ends: assert property (@(posedge clock) disable iff (srst)
    s_expire |=> cpu_reset && slot_reset)
    else $error("expiry did not reset processor and slots");
  chk_disarm_on_expire: assert property (@(posedge clock) disable iff (srst)
    s_expire |=> !en_r)
    else $error("watchdog still armed after its reset");
  chk_arm_write: assert property (@(posedge clock) disable iff (srst)
    wr_wdog && !tif.expire |=> en_r == $past(io_wdata[BWDEP_WDOG_EN_BIT]))
    else $error("arm bit not taken from write");
  chk_mem_lines: assert property (@(posedge clock) disable iff (srst)
    wr_mem |=> mem_di == $past(io_wdata[2]) && mem_sk == $past(io_wdata[1])
      && mem_cs == $past(io_wdata[0]))
    else $error("serial memory lines not driven from write");
  chk_mem_read: assert property (@(posedge clock) disable iff (srst)
    rd_mem |=> io_rvalid && io_rdata == {7'h00, do_r})
    else $error("serial memory read value wrong");
  chk_disarmed_quiet: assert property (@(posedge clock) disable iff (srst)
    !en_r [*2] |=> !tif.expire)
    else $error("disarmed watchdog expired");
  chk_restart_clears: assert property (@(posedge clock) disable iff (srst)
    rd_wdog |=> !tif.expire)
    else $error("restart read did not hold off expiry");
  chk_unmapped_zero: assert property (@(posedge clock) disable iff (srst)
    io_rd && !sel_mem |=> io_rdata == 8'h00)
    else $error("non memory read returned data");

  // host port and serial memory lines
  chk_wdog_read_zero: assert property (@(posedge clock) disable iff (srst)
    rd_wdog |=> io_rdata == 8'h00)
    else $error("restart read returned data");
  chk_unused_zero: assert property (@(posedge clock) disable iff (srst)
    io_rd |=> io_rdata[7:1] == 7'h00)
    else $error("unused register bits read as one");
  chk_rvalid_from_read: assert property (@(posedge clock) disable iff (srst)
    io_rvalid |-> $past(io_rd))
    else $error("read answer without a read strobe");
  chk_mem_hold: assert property (@(posedge clock) disable iff (srst)
    !wr_mem |=> $stable({mem_di, mem_sk, mem_cs}))
    else $error("serial memory lines moved without a write");

  // watchdog arm state and expiry
  chk_arm_hold: assert property (@(posedge clock) disable iff (srst)
    !wr_wdog && !tif.expire |=> $stable(en_r))
    else $error("arm state changed without a write");
  chk_armed_mirror: assert property (@(posedge clock) disable iff (srst)
    wdog_armed == en_r)
    else $error("armed output differs from arm state");
  chk_expire_pulse: assert property (@(posedge clock) disable iff (srst)
    s_expire |=> !tif.expire)
    else $error("expiry lasted more than one cycle");
  chk_quiet_disarmed: assert property (@(posedge clock) disable iff (srst)
    !en_r && !tif.expire && rst_cnt_r == 5'h00 |=> !cpu_reset)
    else $error("reset driven while disarmed and idle");

  ////////////////////////////////////////////////////////////////////////////
  // reset pulse length, counted by a small helper register
  logic [4:0] rst_len_r;
  always_ff @(posedge clock) begin
    if (srst)
      rst_len_r <= 5'h00;
    else
      rst_len_r <= cpu_reset ? rst_len_r + 1'b1 : 5'h00;
  end
  sequence s_pulse_rise;
    $rose(cpu_reset);
  endsequence
  sequence s_pulse_hold;
    cpu_reset [*8];
  endsequence
  chk_pulse_min: assert property (@(posedge clock) disable iff (srst)
    s_pulse_rise |-> s_pulse_hold)
    else $error("reset pulse shorter than eight cycles");
  chk_pulse_max: assert property (@(posedge clock) disable iff (srst)
    cpu_reset |-> rst_len_r < 5'(BWDEP_RST_PULSE_CYC))
    else $error("reset pulse longer than its length");
  chk_slot_with_cpu: assert property (@(posedge clock) disable iff (srst)
    slot_reset == cpu_reset)
    else $error("slot reset differs from processor reset");
endmodule
`default_nettype wire

// ===== test/bwdep_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// serial memory stand-in: captures data in on a rising serial clock
module bwdep_mem_model (
  input  wire logic clock,
  input  wire logic mem_cs,
  input  wire logic mem_sk,
  input  wire logic mem_di,
  output var  logic mem_do
);
  logic sk_r;
  logic bit_r;
  logic tog_r = 1'b0;
  // unselected output keeps changing so a stale bit never looks valid
  always_ff @(posedge clock) begin
    sk_r  <= mem_sk;
    tog_r <= ~tog_r;
    if (mem_cs && mem_sk && !sk_r) bit_r <= mem_di;
  end
  assign mem_do = mem_cs ? bit_r : tog_r;
endmodule
`default_nettype wire

// ===== test/test_board_watchdog_and_eeprom_port.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module test_board_watchdog_and_eeprom_port;
  import bwdep_pkg::*;
  logic clock = 0, srst = 1, io_rd = 0, io_wr = 0, mem_do;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00, io_rdata, d, v, wa;
  logic io_rvalid, cpu_reset, slot_reset, mem_cs, mem_sk, mem_di, wdog_armed;
  int failures = 0, n_checks = 0, seed = 9490, k, n, rst_cyc = 0, slot_bad = 0;
  always #5 clock = ~clock;
  bwdep_top #(.TIMEOUT_CYC(26'd100)) dut_u (.clock, .srst, .io_addr, .io_rd, .io_wr,
    .io_wdata, .io_rdata, .io_rvalid, .cpu_reset, .slot_reset, .mem_cs, .mem_sk, .mem_di,
    .mem_do, .wdog_armed);
  bwdep_mem_model mem_u (.clock, .mem_cs, .mem_sk, .mem_di, .mem_do);
  // reset pulse watchers
  always @(posedge clock) begin
    if (cpu_reset !== 1'b0) rst_cyc++;
    if (slot_reset !== cpu_reset) slot_bad++;
  end
  task automatic stop_test;
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] w);
    @(posedge clock);
    io_addr <= a; io_wdata <= w; io_wr <= 1'b1;
    @(posedge clock);
    io_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] r);
    @(posedge clock);
    io_addr <= a; io_rd <= 1'b1;
    @(posedge clock);
    io_rd <= 1'b0;
    #1;
    `CHK(io_rvalid, 1'b1)
    r = io_rdata;
  endtask
  // expected read data for a selected memory or any other address
  function automatic logic [7:0] exp_rd(input logic [15:0] a, input logic b);
    return (a == BWDEP_ADDR_SERMEM) ? {7'h00, b} : 8'h00;
  endfunction
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    #1;
    `CHK(({cpu_reset, slot_reset, mem_cs, mem_sk, mem_di, wdog_armed}), 6'h00)
    // word address from the upper, user half of the memory, sent msb first
    wa = {2'($random(seed)), 6'(BWDEP_MEM_USER0 + ($random(seed) & 31))};
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      d[2] = wa[7 - i];
      wr(BWDEP_ADDR_SERMEM, {d[7:2], 2'b01});
      wr(BWDEP_ADDR_SERMEM, {d[7:2], 2'b11});
      wr(16'h0102 + 16'(i), ~d);
      `CHK(({mem_di, mem_sk, mem_cs}), ({d[2], 2'b11}))
      rd(BWDEP_ADDR_SERMEM, v);
      `CHK(v, exp_rd(BWDEP_ADDR_SERMEM, d[2]))
      rd(BWDEP_ADDR_WDOG, v);
      `CHK(v, exp_rd(BWDEP_ADDR_WDOG, 1'b0))
    end
    wr(BWDEP_ADDR_SERMEM, 8'hFE);
    rd(BWDEP_ADDR_SERMEM, v);
    `CHK(v[7:1], 7'h00)
    wr(BWDEP_ADDR_WDOG, 8'h02);
    `CHK(wdog_armed, 1'b0)
    wr(BWDEP_ADDR_WDOG, 8'h01);
    `CHK(wdog_armed, 1'b1)
    wr(BWDEP_ADDR_WDOG, 8'h00);
    `CHK(wdog_armed, 1'b0)
    k = rst_cyc;
    repeat (150) @(posedge clock);
    `CHK(rst_cyc, k)
    // regular restarts keep an armed timer quiet
    wr(BWDEP_ADDR_WDOG, 8'h01);
    repeat (6) begin
      repeat (60 + ($random(seed) & 31)) @(posedge clock);
      rd(BWDEP_ADDR_WDOG, v);
    end
    `CHK(rst_cyc, k)
    n = 0;
    while (cpu_reset !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHK(n >= 95 && n <= 105, 1'b1)
    if (n >= 300) stop_test;
    k = rst_cyc;
    repeat (40) @(posedge clock);
    #1;
    `CHK(rst_cyc - k, BWDEP_RST_PULSE_CYC)
    `CHK(slot_bad, 0)
    `CHK(wdog_armed, 1'b0)
    // reset in mid-run drops an armed timer
    wr(BWDEP_ADDR_WDOG, 8'h01);
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    #1;
    `CHK(({wdog_armed, mem_cs}), 2'b00)
    stop_test;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    stop_test;
  end
endmodule
`default_nettype wire
